/* dv/vpif_frame_peer.sv */
// far side model: descriptor source and result sink
`timescale 1ns/1ps
`default_nettype none
module vpif_frame_peer #(
   parameter int PORTS = 28,
   parameter int VID_W = 12,
   localparam int PW = $clog2(PORTS)
) (
   input wire logic hclk, // clock
   input wire logic frm_ready, // accept
   output logic frm_valid, // valid
   output logic [PW-1:0] frm_src_port, // port
   output logic frm_tagged, // tagged
   output logic [VID_W-1:0] frm_tag_vid, // tag id
   input wire logic fwd_valid, // result
   input wire logic [VID_W-1:0] fwd_vid, // vlan
   input wire logic [PORTS-1:0] fwd_dest_mask, // dest
   input wire logic [PORTS-1:0] fwd_strip_mask // strip
);
   logic [VID_W+2*PORTS-1:0] got = '0;
   int unsigned n_res = 0;
   initial begin
      frm_valid = 1'b0;
      frm_src_port = '0;
      frm_tagged = 1'b0;
      frm_tag_vid = '0;
   end
   always @(posedge hclk) begin
      if (fwd_valid === 1'b1) begin
         got <= {fwd_vid, fwd_dest_mask, fwd_strip_mask};
         n_res <= n_res + 1;
      end
   end
   // released fields invert so stale values never look live
   task automatic send(input logic [PW-1:0] src, input logic tg, input logic [VID_W-1:0] vlan_identifier);
      frm_valid <= 1'b1;
      frm_src_port <= src;
      frm_tagged <= tg;
      frm_tag_vid <= vlan_identifier;
      @(posedge hclk);
      // held until taken; the bench watchdog ends a stuck wait
      while (frm_ready !== 1'b1) begin
         @(posedge hclk);
      end
      frm_valid <= 1'b0;
      frm_src_port <= ~src;
      frm_tagged <= ~tg;
      frm_tag_vid <= ~vlan_identifier;
   endtask : send
endmodule : vpif_frame_peer
`default_nettype wire

/* dv/vpif_top_asserts.sv */
// port checker for the vlan port isolation filter
`timescale 1ns/1ps
`default_nettype none
module vpif_top_chk #(
   parameter int PORTS = 28,
   parameter int VID_W = 12,
   localparam int PW = $clog2(PORTS)
) (
   input wire logic hclk, // clock
   input wire logic hresetn, // reset, low
   input wire logic hreadyout, // ready
   input wire logic hresp, // response
   input wire logic frm_valid, // valid
   input wire logic frm_ready, // accept
   input wire logic [PW-1:0] frm_src_port, // port
   input wire logic frm_tagged, // tagged
   input wire logic [VID_W-1:0] frm_tag_vid, // tag id
   input wire logic fwd_valid, // result
   input wire logic [VID_W-1:0] fwd_vid, // vlan
   input wire logic [PORTS-1:0] fwd_dest_mask, // dest
   input wire logic [PORTS-1:0] fwd_strip_mask // strip
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus answer not zero wait okay");
   property p_lat; frm_valid && frm_ready |-> ##2 fwd_valid; endproperty
   a_lat: assert property (p_lat) else $error("result missing");
   property p_pulse; fwd_valid |-> $past(frm_valid && frm_ready, 2); endproperty
   a_pulse: assert property (p_pulse) else $error("result without descriptor");
   property p_vid; frm_valid && frm_ready && frm_tagged |-> ##2 fwd_vid == $past(frm_tag_vid, 2);
   endproperty
   a_vid: assert property (p_vid) else $error("tagged vlan id wrong");
   property p_strip; (fwd_strip_mask & ~fwd_dest_mask) == '0; endproperty
   a_strip: assert property (p_strip) else $error("strip outside dest");
   property p_stand; !fwd_valid |-> fwd_dest_mask == '0 && fwd_strip_mask == '0; endproperty
   a_stand: assert property (p_stand) else $error("masks outside pulse");
   property p_src; fwd_valid |-> !fwd_dest_mask[$past(frm_src_port, 2)]; endproperty
   a_src: assert property (p_src) else $error("frame sent back to source");
   property p_init; $rose(hresetn) |-> !frm_ready [*8]; endproperty
   a_init: assert property (p_init) else $error("ready during table init");
endmodule : vpif_top_chk
bind vpif_top vpif_top_chk #(.PORTS(PORTS), .VID_W(VID_W)) chk_i (.hclk(hclk),
   .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .frm_valid(frm_valid),
   .frm_ready(frm_ready), .frm_src_port(frm_src_port), .frm_tagged(frm_tagged),
   .frm_tag_vid(frm_tag_vid), .fwd_valid(fwd_valid), .fwd_vid(fwd_vid),
   .fwd_dest_mask(fwd_dest_mask), .fwd_strip_mask(fwd_strip_mask));
`default_nettype wire

/* dv/vpif_top_bench.sv */
// self-checking bench for the vlan port isolation filter
`timescale 1ns/1ps
`default_nettype none
module vpif_top_bench
   import vpif_pkg::*;
;
   localparam int P = 28;
   localparam int VW = 4; // shrinks the table init walk to 32 cycles
   localparam int PW = $clog2(P);
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout, hresp, frm_valid, frm_ready, frm_tagged, fwd_valid;
   logic [31:0] hrdata;
   logic [PW-1:0] frm_src_port;
   logic [VW-1:0] frm_tag_vid, fwd_vid;
   logic [P-1:0] fwd_dest_mask, fwd_strip_mask;
   int n_errors = 0;
   int samples_checked = 0;
   always #10 hclk = ~hclk;
   vpif_top #(.PORTS(P), .VID_W(VW)) vpif_top_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .frm_valid(frm_valid), .frm_ready(frm_ready),
      .frm_src_port(frm_src_port), .frm_tagged(frm_tagged), .frm_tag_vid(frm_tag_vid),
      .fwd_valid(fwd_valid), .fwd_vid(fwd_vid), .fwd_dest_mask(fwd_dest_mask),
      .fwd_strip_mask(fwd_strip_mask));
   vpif_frame_peer #(.PORTS(P), .VID_W(VW)) vpif_frame_peer_i (.hclk(hclk),
      .frm_ready(frm_ready), .frm_valid(frm_valid), .frm_src_port(frm_src_port),
      .frm_tagged(frm_tagged), .frm_tag_vid(frm_tag_vid), .fwd_valid(fwd_valid),
      .fwd_vid(fwd_vid), .fwd_dest_mask(fwd_dest_mask), .fwd_strip_mask(fwd_strip_mask));
   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      // no cycle count assumed; only the watchdog ends a stuck wait
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= VPIF_HTRANS_NONSEQ;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         @(posedge hclk);
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         @(posedge hclk);
      end
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0000_0000, x);
      chk(nm, e, x);
   endtask : rdc
   task automatic fr(input logic [PW-1:0] s, input logic tg, input logic [VW-1:0] v,
      input logic [VW-1:0] ev, input logic [P-1:0] ed, input logic [P-1:0] es);
      int unsigned c;
      int n;
      c = vpif_frame_peer_i.n_res;
      n = 0;
      vpif_frame_peer_i.send(s, tg, v);
      while (vpif_frame_peer_i.n_res == c && n < 10) begin
         @(posedge hclk);
         n++;
      end
      // a missing result must not pass on a stale capture
      chk("fwd_count", c + 1, vpif_frame_peer_i.n_res);
      chk("fwd", {ev, ed, es}, vpif_frame_peer_i.got);
   endtask : fr
   task automatic t_defaults();
      logic [31:0] s;
      int n;
      s = 32'h0000_0001;
      n = 0;
      while (s[VPIF_STATUS_BUSY_BIT] !== 1'b0 && n < 100) begin
         ahb(1'b0, VPIF_STATUS_OFS, 32'h0000_0000, s);
         n++;
      end
      chk("busy", 1'b0, s[VPIF_STATUS_BUSY_BIT]);
      rdc("iso_en", VPIF_ISO_EN_OFS, 32'h0000_0000);
      wr(8'h40, 32'hFFFF_FFFF);
      rdc("unmapped", 8'h40, 32'h0000_0000);
      fr(5'h03, 1'b0, 4'h0, 4'h1, 28'hFFFFFF7, 28'hFFFFFF7);
      fr(5'h00, 1'b1, 4'h1, 4'h1, 28'hFFFFFFE, 28'hFFFFFFE);
   endtask : t_defaults
   task automatic t_vlan();
      wr(VPIF_TBL_VID_OFS, 32'h0000_0002);
      wr(VPIF_TBL_MEMBER_OFS, 32'h0000_000E);
      wr(VPIF_TBL_UNTAG_OFS, 32'h0000_0006);
      wr(VPIF_CMD_OFS, 32'h0000_0001 << VPIF_CMD_VLAN_BIT);
      wr(VPIF_PORT_DEFAULT_VLAN_ID_SEL_OFS, 32'h0000_0001);
      wr(VPIF_PORT_DEFAULT_VLAN_ID_VAL_OFS, 32'h0000_0002);
      rdc("port_default_vlan_id", VPIF_PORT_DEFAULT_VLAN_ID_VAL_OFS, 32'h0000_0002);
      fr(5'h01, 1'b0, 4'h0, 4'h2, 28'h000000C, 28'h0000004);
      fr(5'h03, 1'b1, 4'h2, 4'h2, 28'h0000006, 28'h0000006);
   endtask : t_vlan
   task automatic t_iso();
      wr(VPIF_ISO_EN_OFS, 32'h0000_0006);
      rdc("iso_en", VPIF_ISO_EN_OFS, 32'h0000_0006);
      fr(5'h01, 1'b0, 4'h0, 4'h2, 28'h0000008, 28'h0000000);
      fr(5'h03, 1'b1, 4'h2, 4'h2, 28'h0000006, 28'h0000006);
      fr(5'h02, 1'b1, 4'h1, 4'h1, 28'hFFFFFF9, 28'hFFFFFF9);
      wr(VPIF_PORT_DEFAULT_VLAN_ID_SEL_OFS, 32'h0000_0001);
      wr(VPIF_PV_MASK_OFS, 32'h0000_0001);
      wr(VPIF_CMD_OFS, 32'h0000_0001 << VPIF_CMD_PV_BIT);
      fr(5'h01, 1'b1, 4'h1, 4'h1, 28'h0000001, 28'h0000001);
      fr(5'h01, 1'b1, 4'h2, 4'h2, 28'h0000000, 28'h0000000);
      wr(VPIF_ISO_EN_OFS, 32'h0000_0000);
      fr(5'h01, 1'b1, 4'h2, 4'h2, 28'h000000C, 28'h0000004);
   endtask : t_iso
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_defaults();
      t_vlan();
      t_iso();
      complete_run();
   end
   // whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      complete_run();
   end
endmodule : vpif_top_bench
`default_nettype wire

/* rtl/vpif_dummy_unused.sv */
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* rtl/vpif_mem.sv */
// simple dual-port table memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module vpif_mem #(
   parameter int DW = 56,
   parameter int AW = 12
) (
   input wire logic hclk, // core clock
   input wire logic hresetn, // async reset, active low
   input wire logic we, // write strobe
   input wire logic [AW-1:0] waddr, // write address
   input wire logic [DW-1:0] wdata, // write data
   input wire logic [AW-1:0] raddr, // read address
   output logic [DW-1:0] rdata // read data, one cycle after raddr
);
   logic [DW-1:0] mem [2**AW];

   // array has no reset; contents are loaded by the owner's init walk
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule : vpif_mem
`default_nettype wire

/* rtl/vpif_pkg.sv */
// shared constants for the vlan port isolation filter
package vpif_pkg;
   localparam int VPIF_PORTS = 28;
   localparam int VPIF_VID_W = 12;
   localparam int VPIF_ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] VPIF_ISO_EN_OFS = 8'h00;
   localparam logic [7:0] VPIF_PORT_DEFAULT_VLAN_ID_SEL_OFS = 8'h04;
   localparam logic [7:0] VPIF_PORT_DEFAULT_VLAN_ID_VAL_OFS = 8'h08;
   localparam logic [7:0] VPIF_TBL_VID_OFS = 8'h0C;
   localparam logic [7:0] VPIF_TBL_MEMBER_OFS = 8'h10;
   localparam logic [7:0] VPIF_TBL_UNTAG_OFS = 8'h14;
   localparam logic [7:0] VPIF_CMD_OFS = 8'h18;
   localparam logic [7:0] VPIF_PV_MASK_OFS = 8'h1C;
   localparam logic [7:0] VPIF_STATUS_OFS = 8'h20;
   // field positions
   localparam int VPIF_CMD_VLAN_BIT = 0;
   localparam int VPIF_CMD_PV_BIT = 1;
   localparam int VPIF_STATUS_BUSY_BIT = 0;
   // reset values, ahb transfer code and walk states
   localparam logic [11:0] VPIF_DEFAULT_VID = 12'h001;
   localparam logic [31:0] VPIF_ISO_EN_RST = 32'h0000_0000;
   localparam logic [1:0] VPIF_HTRANS_NONSEQ = 2'h2;
   typedef enum logic [0:0] {VPIF_ST_INIT, VPIF_ST_RUN} vpif_state_t;
endpackage : vpif_pkg

/* rtl/vpif_top.sv */
// vlan classification, private vlan isolation and egress tag masks
//
// Overview of operation
// - promiscuous source: destinations limited by vlan membership mask, less the source port itself
// - isolated source: private mask and vlan mask are anded together
// - isolated egress ports receive only frames from promiscuous sources
// - one isolation role per port, shared by every private vlan
// - untagged frame takes the ingress port default vlan identifier
// - tagged frame takes the vlan identifier carried in its tag
// - untagged members of the vlan get the tag stripped on egress
// - tagged members of the vlan keep the tag unchanged on egress
// - never forward to a port outside the classified vlan
// - reset defaults: all ports in vlan 1 and private vlan 1
// - private vlan membership is a per-source-port mask, no vlan link
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vpif_top
   import vpif_pkg::*;
#(
   parameter int PORTS = VPIF_PORTS,
   parameter int VID_W = VPIF_VID_W,
   localparam int PW = $clog2(PORTS)
) (
   input wire logic hclk, // core clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [31:0] hrdata, // ahb read data
   input wire logic frm_valid, // frame descriptor valid
   output logic frm_ready, // descriptor accepted when high
   input wire logic [PW-1:0] frm_src_port, // ingress port index
   input wire logic frm_tagged, // frame arrived with a vlan tag
   input wire logic [VID_W-1:0] frm_tag_vid, // vlan identifier from the tag
   output logic fwd_valid, // result pulse
   output logic [VID_W-1:0] fwd_vid, // classified vlan identifier
   output logic [PORTS-1:0] fwd_dest_mask, // destination ports
   output logic [PORTS-1:0] fwd_strip_mask // destinations sending untagged
);
   localparam logic [PW-1:0] LAST_PORT = PW'(PORTS - 1);
   localparam logic [VID_W-1:0] DEF_VID = VID_W'(VPIF_DEFAULT_VID);
   // walk counter spans the larger table so narrow vlan ids still fill all ports
   localparam int IW = (VID_W > PW) ? VID_W : PW;

   // register state
   logic [PORTS-1:0] iso_en, next_iso_en;
   logic [PW-1:0] port_default_vlan_id_sel, next_port_default_vlan_id_sel;
   logic [VID_W-1:0] tbl_vid, next_tbl_vid;
   logic [PORTS-1:0] tbl_member, next_tbl_member;
   logic [PORTS-1:0] tbl_untag, next_tbl_untag;
   logic [PORTS-1:0] pv_mask, next_pv_mask;
   logic [VID_W-1:0] port_default_vlan_id [PORTS];
   logic dp_write, next_dp_write;
   logic [7:0] dp_addr, next_dp_addr;
   logic [31:0] next_hrdata;
   logic [PORTS-1:0] port_default_vlan_id_we;
   logic sw_vlan_commit, sw_pv_commit;

   // init walk state
   vpif_state_t state, next_state;
   logic [IW-1:0] init_addr, next_init_addr;

   // pipeline state
   logic s1_valid, next_s1_valid;
   logic [PW-1:0] s1_src, next_s1_src;
   logic [VID_W-1:0] s1_vid, next_s1_vid;
   logic next_fwd_valid;
   logic [VID_W-1:0] next_fwd_vid;
   logic [PORTS-1:0] next_fwd_dest, next_fwd_strip;

   // memory ports
   logic vt_we, pv_we;
   logic [VID_W-1:0] vt_waddr, vt_raddr;
   logic [2*PORTS-1:0] vt_wdata, vt_rdata;
   logic [PW-1:0] pv_waddr;
   logic [PORTS-1:0] pv_wdata, pv_rdata;
   logic [VID_W-1:0] class_vid;
   logic busy;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign busy = (state == VPIF_ST_INIT);
   // table ram cannot be reset; lookups wait for the init walk
   assign frm_ready = !busy;

   // ahb address phase capture and read data
   always_comb begin
      next_dp_write = 1'b0;
      next_dp_addr = dp_addr;
      next_hrdata = hrdata;
      if (hsel && hready && htrans == VPIF_HTRANS_NONSEQ) begin
         next_dp_write = hwrite;
         next_dp_addr = haddr[7:0];
         next_hrdata = 32'h0000_0000;
         if (!hwrite) begin
            case (haddr[7:0])
               VPIF_ISO_EN_OFS: next_hrdata[PORTS-1:0] = iso_en;
               VPIF_PORT_DEFAULT_VLAN_ID_SEL_OFS: next_hrdata[PW-1:0] = port_default_vlan_id_sel;
               VPIF_PORT_DEFAULT_VLAN_ID_VAL_OFS: next_hrdata[VID_W-1:0] = port_default_vlan_id[port_default_vlan_id_sel];
               VPIF_TBL_VID_OFS: next_hrdata[VID_W-1:0] = tbl_vid;
               VPIF_TBL_MEMBER_OFS: next_hrdata[PORTS-1:0] = tbl_member;
               VPIF_TBL_UNTAG_OFS: next_hrdata[PORTS-1:0] = tbl_untag;
               VPIF_PV_MASK_OFS: next_hrdata[PORTS-1:0] = pv_mask;
               VPIF_STATUS_OFS: next_hrdata[VPIF_STATUS_BUSY_BIT] = busy;
               default: next_hrdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ahb data phase writes
   always_comb begin
      next_iso_en = iso_en;
      next_port_default_vlan_id_sel = port_default_vlan_id_sel;
      next_tbl_vid = tbl_vid;
      next_tbl_member = tbl_member;
      next_tbl_untag = tbl_untag;
      next_pv_mask = pv_mask;
      sw_vlan_commit = 1'b0;
      sw_pv_commit = 1'b0;
      if (dp_write) begin
         case (dp_addr)
            VPIF_ISO_EN_OFS: next_iso_en = hwdata[PORTS-1:0];
            VPIF_PORT_DEFAULT_VLAN_ID_SEL_OFS: next_port_default_vlan_id_sel = hwdata[PW-1:0];
            VPIF_TBL_VID_OFS: next_tbl_vid = hwdata[VID_W-1:0];
            VPIF_TBL_MEMBER_OFS: next_tbl_member = hwdata[PORTS-1:0];
            VPIF_TBL_UNTAG_OFS: next_tbl_untag = hwdata[PORTS-1:0];
            VPIF_PV_MASK_OFS: next_pv_mask = hwdata[PORTS-1:0];
            VPIF_CMD_OFS: begin
               sw_vlan_commit = hwdata[VPIF_CMD_VLAN_BIT];
               sw_pv_commit = hwdata[VPIF_CMD_PV_BIT] && port_default_vlan_id_sel <= LAST_PORT;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         iso_en <= VPIF_ISO_EN_RST[PORTS-1:0];
         port_default_vlan_id_sel <= '0;
         tbl_vid <= '0;
         tbl_member <= '0;
         tbl_untag <= '0;
         pv_mask <= '0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         iso_en <= next_iso_en;
         port_default_vlan_id_sel <= next_port_default_vlan_id_sel;
         tbl_vid <= next_tbl_vid;
         tbl_member <= next_tbl_member;
         tbl_untag <= next_tbl_untag;
         pv_mask <= next_pv_mask;
         dp_write <= next_dp_write;
         dp_addr <= next_dp_addr;
         hrdata <= next_hrdata;
      end
   end

   // per-port default vlan identifier, reset to vlan 1
   for (genvar p = 0; p < PORTS; p++) begin : g_port_default_vlan_id
      logic [VID_W-1:0] next_port_default_vlan_id;
      assign port_default_vlan_id_we[p] = dp_write && dp_addr == VPIF_PORT_DEFAULT_VLAN_ID_VAL_OFS && port_default_vlan_id_sel == PW'(p);
      always_comb begin
         next_port_default_vlan_id = port_default_vlan_id[p];
         if (port_default_vlan_id_we[p]) begin
            next_port_default_vlan_id = hwdata[VID_W-1:0];
         end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            port_default_vlan_id[p] <= DEF_VID;
         end else begin
            port_default_vlan_id[p] <= next_port_default_vlan_id;
         end
      end
   end

   // init walk: vlan 1 holds every port untagged, others empty, every
   // source port sees all ports in private vlan 1
   always_comb begin
      next_state = state;
      next_init_addr = init_addr;
      case (state)
         VPIF_ST_INIT: begin
            next_init_addr = init_addr + 1'b1;
            if (&init_addr) begin
               next_state = VPIF_ST_RUN;
            end
         end
         VPIF_ST_RUN: next_init_addr = '0;
         default: next_state = VPIF_ST_INIT;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= VPIF_ST_INIT;
         init_addr <= '0;
      end else begin
         state <= next_state;
         init_addr <= next_init_addr;
      end
   end

   // write port mux; the walk owns the tables while busy
   always_comb begin
      if (busy) begin
         // vlan entries may be written twice with the same value; harmless
         vt_we = 1'b1;
         vt_waddr = init_addr[VID_W-1:0];
         vt_wdata = (init_addr[VID_W-1:0] == DEF_VID) ? '1 : '0;
         pv_we = init_addr <= IW'(LAST_PORT);
         pv_waddr = init_addr[PW-1:0];
         pv_wdata = '1;
      end else begin
         vt_we = sw_vlan_commit;
         vt_waddr = tbl_vid;
         vt_wdata = {tbl_untag, tbl_member};
         pv_we = sw_pv_commit;
         pv_waddr = port_default_vlan_id_sel;
         pv_wdata = pv_mask;
      end
   end

   // classification of the incoming descriptor
   always_comb begin
      class_vid = frm_tagged ? frm_tag_vid : port_default_vlan_id[frm_src_port];
      if (!frm_tagged && frm_src_port > LAST_PORT) begin
         class_vid = '0;
      end
      vt_raddr = class_vid;
   end

   vpif_mem #(
      .DW(2 * PORTS),
      .AW(VID_W)
   ) u_vlan_tbl (
      .hclk(hclk),
      .hresetn(hresetn),
      .we(vt_we),
      .waddr(vt_waddr),
      .wdata(vt_wdata),
      .raddr(vt_raddr),
      .rdata(vt_rdata)
   );

   vpif_mem #(
      .DW(PORTS),
      .AW(PW)
   ) u_pvlan_tbl (
      .hclk(hclk),
      .hresetn(hresetn),
      .we(pv_we),
      .waddr(pv_waddr),
      .wdata(pv_wdata),
      .raddr(frm_src_port),
      .rdata(pv_rdata)
   );

   // stage two: masks arrive from the tables, destination is formed
   always_comb begin
      logic [PORTS-1:0] member;
      logic [PORTS-1:0] allowed;
      member = vt_rdata[PORTS-1:0];
      allowed = member;
      if (s1_src <= LAST_PORT && iso_en[s1_src]) begin
         allowed = member & pv_rdata & ~iso_en;
      end
      if (s1_src <= LAST_PORT) begin
         allowed[s1_src] = 1'b0;
      end else begin
         allowed = '0;
      end
      next_s1_valid = frm_valid && frm_ready;
      next_s1_src = frm_src_port;
      next_s1_vid = class_vid;
      next_fwd_valid = s1_valid;
      next_fwd_vid = s1_vid;
      next_fwd_dest = s1_valid ? allowed : '0;
      // strip where untagged member, keep tag elsewhere
      next_fwd_strip = s1_valid ? (allowed & vt_rdata[2*PORTS-1:PORTS]) : '0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_valid <= 1'b0;
         s1_src <= '0;
         s1_vid <= '0;
         fwd_valid <= 1'b0;
         fwd_vid <= '0;
         fwd_dest_mask <= '0;
         fwd_strip_mask <= '0;
      end else begin
         s1_valid <= next_s1_valid;
         s1_src <= next_s1_src;
         s1_vid <= next_s1_vid;
         fwd_valid <= next_fwd_valid;
         fwd_vid <= next_fwd_vid;
         fwd_dest_mask <= next_fwd_dest;
         fwd_strip_mask <= next_fwd_strip;
      end
   end
endmodule : vpif_top
`default_nettype wire
